/* File: design/iww_top.sv */
// independent window watchdog with an APB register port
// assumes wdt_tick is a one-cycle enable from the dedicated watchdog clock, synchronous to pclk
//
// Summary of operation
// [RL1] counter ticks from dedicated clock through prescaler 1,16,32,64,128,256
// [RL2] 14-bit down-counter decrements once per prescaled tick
// [RL3] auto-start mode counts on its own after reset release
// [RL4] register start mode starts on refresh: write 00h then FFh
// [RL5] reset stops counting and restores counter and all registers
// [RL6] counting stops on underflow or refresh error
// [RL7] auto-start resumes after reset or after issuing the interrupt request
// [RL8] register start mode stays halted until a new refresh
// [RL9] configurable window start and end; refresh allowed only between
// [RL10] refresh outside window is an error; errors and underflow drive reset or interrupt
// [RL11] status register shows the current counter value
// [RL12] separate event pulses for underflow and refresh error
// [RL13] output telling whether counting stops in sleep mode
// [RL14] one bit picks reset or interrupt, from option word or reset control
// [RL15] period select 00 gives 128 cycles, start value 007Fh
// [RL16] FFh refreshes only if the previous refresh register write was 00h
// [RL17] start mode latched at reset release, kept until next reset
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "iww_params.svh"

module iww_top #(
    parameter int PRESC_W = 8
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // count source and system state
    input  wire logic               wdt_tick,
    input  wire logic               sleep_mode,
    input  wire iww_pkg::iww_cfg_t  option_config_word,
    // watchdog outputs
    output logic                    wdt_reset_req,
    output logic                    nmi_req,
    output logic                    evt_underflow,
    output logic                    evt_refresh_err,
    output logic                    sleep_stop_ctrl,
    output logic                    irq
);

    // ****************************************
    // declarations
    // ****************************************
    iww_pkg::iww_state_t st_r;
    iww_pkg::iww_cfg_t   opt_r;
    iww_pkg::iww_cfg_t   eff;
    logic                latched_r;
    logic [15:0]         ctrl_r;
    logic                rstirq_r;
    logic                slcstp_r;
    logic [1:0]          irq_st_r, irq_en_r;
    logic [13:0]         cnt_r;
    logic                pend00_r;
    logic [31:0]         rdata_r;
    logic                reset_req_r, nmi_r, evt_uf_r, evt_err_r, slc_out_r;
    logic                wr_en, rd_setup, mapped, refresh_hit, in_window, tick, run;
    logic                underflow, ref_err, ref_ok, start_auto, resume_auto, reload;
    logic [13:0]         top, quarter, win_hi, win_lo;
    logic [31:0]         rd_val;

    // point at n quarters of the period
    function automatic logic [13:0] quarter_pt(input logic [13:0] q, input logic [2:0] n);
        logic [16:0] p;
        p = 17'(q) * 17'(n);
        return p[13:0];
    endfunction

    // ****************************************
    // apb slave
    // ****************************************
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = rdata_r;

    always_comb
    begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == `IWW_OFF_REFRESH)
            rd_val = 32'h0000_0000;
        else if (paddr == `IWW_OFF_CTRL)
            rd_val = {16'h0000, ctrl_r};
        else if (paddr == `IWW_OFF_STATUS)
            rd_val = {16'h0000, irq_st_r[`IWW_IRQ_ERR], irq_st_r[`IWW_IRQ_UF], cnt_r}; // [RL11]
        else if (paddr == `IWW_OFF_RSTCTL)
            rd_val = {24'h00_0000, rstirq_r, 7'h00};
        else if (paddr == `IWW_OFF_STOPCTL)
            rd_val = {31'h0000_0000, slcstp_r};
        else if (paddr == `IWW_OFF_IRQ_ST)
            rd_val = {30'h0000_0000, irq_st_r};
        else if (paddr == `IWW_OFF_IRQ_CLR)
            rd_val = 32'h0000_0000;
        else if (paddr == `IWW_OFF_IRQ_EN)
            rd_val = {30'h0000_0000, irq_en_r};
        else
            mapped = 1'b0;
    end

    // read data is sampled in the setup cycle so the access needs no wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_r <= 32'h0000_0000;
        else if (rd_setup)
            rdata_r <= rd_val;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= `IWW_CTRL_RST; // [RL5]
            rstirq_r <= `IWW_RSTCTL_RST;
            slcstp_r <= `IWW_STOPCTL_RST;
            irq_en_r <= 2'h0;
        end
        else if (wr_en)
        begin
            if (paddr == `IWW_OFF_CTRL)
                ctrl_r <= pwdata[15:0];
            else if (paddr == `IWW_OFF_RSTCTL)
                rstirq_r <= pwdata[`IWW_RSTCTL_SEL];
            else if (paddr == `IWW_OFF_STOPCTL)
                slcstp_r <= pwdata[`IWW_STOPCTL_SLC];
            else if (paddr == `IWW_OFF_IRQ_EN)
                irq_en_r <= pwdata[1:0];
        end
    end

    // ****************************************
    // mode latch and effective configuration
    // ****************************************
    // the option word is caught on the first edge after reset release, never by the reset itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latched_r <= 1'b0;
            opt_r     <= '0;
        end
        else if (!latched_r)
        begin
            latched_r <= 1'b1; // [RL17]
            opt_r     <= option_config_word;
        end
    end

    always_comb
    begin
        if (opt_r.auto_start)
            eff = opt_r; // [RL14]
        else
        begin
            eff             = '0;
            eff.rst_irq_sel = rstirq_r; // [RL14]
            eff.slcstp      = slcstp_r;
            eff.rpss        = ctrl_r[`IWW_CTRL_RPSS_LSB +: 2];
            eff.rpes        = ctrl_r[`IWW_CTRL_RPES_LSB +: 2];
            eff.cks         = ctrl_r[`IWW_CTRL_CKS_LSB +: 3];
            eff.timeout_period_select = ctrl_r[`IWW_CTRL_TPS_LSB +: 2];
        end
    end

    always_comb
    begin
        case (eff.timeout_period_select)
            2'h0:    top = `IWW_TOP_SEL0; // [RL15]
            2'h1:    top = `IWW_TOP_SEL1;
            2'h2:    top = `IWW_TOP_SEL2;
            default: top = `IWW_TOP_SEL3;
        endcase
    end

    // ****************************************
    // refresh sequence and window
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend00_r <= 1'b0;
        else if (wr_en && paddr == `IWW_OFF_REFRESH)
            pend00_r <= (pwdata[7:0] == `IWW_REFRESH_FIRST); // [RL16]
    end

    assign refresh_hit = wr_en && (paddr == `IWW_OFF_REFRESH) && pend00_r
                         && (pwdata[7:0] == `IWW_REFRESH_LAST); // [RL16]

    // window start counts quarters down from the top, window end quarters up from zero
    assign quarter   = (top + 14'h0001) >> 2;
    assign win_hi    = quarter_pt(quarter, 3'h4 - {1'b0, eff.rpss}) - 14'h0001; // [RL9]
    assign win_lo    = quarter_pt(quarter, {1'b0, eff.rpes}); // [RL9]
    assign in_window = (cnt_r <= win_hi) && (cnt_r >= win_lo); // [RL9]

    // ****************************************
    // counting state machine
    // ****************************************
    assign run         = (st_r == iww_pkg::ST_COUNT) && !(sleep_mode && eff.slcstp);
    assign ref_err     = (st_r == iww_pkg::ST_COUNT) && refresh_hit && !in_window; // [RL10]
    assign underflow   = (st_r == iww_pkg::ST_COUNT) && tick && (cnt_r == 14'h0000) && !refresh_hit;
    assign ref_ok      = refresh_hit && !opt_r.auto_start && latched_r
                         && ((st_r != iww_pkg::ST_COUNT) || in_window); // [RL4] [RL8]
    assign start_auto  = latched_r && opt_r.auto_start && (st_r == iww_pkg::ST_IDLE); // [RL3]
    assign resume_auto = opt_r.auto_start && eff.rst_irq_sel && (st_r == iww_pkg::ST_STOP); // [RL7]
    assign reload      = ref_ok || start_auto || resume_auto;

    iww_prescaler #(
        .CNT_W    (PRESC_W)
    ) u_presc (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (run),
        .clr      (reload),
        .sel      (eff.cks),
        .tick_in  (wdt_tick),
        .tick_out (tick)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= iww_pkg::ST_IDLE; // [RL5]
        else
        begin
            case (st_r)
                iww_pkg::ST_IDLE:
                    if (reload)
                        st_r <= iww_pkg::ST_COUNT;
                iww_pkg::ST_COUNT:
                    if (underflow || ref_err)
                        st_r <= iww_pkg::ST_STOP; // [RL6]
                iww_pkg::ST_STOP:
                    if (reload)
                        st_r <= iww_pkg::ST_COUNT; // [RL7] [RL8]
                default:
                    st_r <= iww_pkg::ST_IDLE;
            endcase
        end
    end

    // the counter holds at zero after an underflow rather than wrapping
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= 14'h0000; // [RL5]
        else if (reload)
            cnt_r <= top; // [RL4]
        else if (tick && cnt_r != 14'h0000)
            cnt_r <= cnt_r - 14'h0001; // [RL2]
    end

    // ****************************************
    // outputs and interrupt
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_uf_r    <= 1'b0;
            evt_err_r   <= 1'b0;
            nmi_r       <= 1'b0;
            reset_req_r <= 1'b0;
            slc_out_r   <= 1'b0;
        end
        else
        begin
            evt_uf_r  <= underflow; // [RL12]
            evt_err_r <= ref_err; // [RL12]
            nmi_r     <= (underflow || ref_err) && eff.rst_irq_sel; // [RL10]
            slc_out_r <= eff.slcstp; // [RL13]
            // the request stands until the system answers it with a reset
            if ((underflow || ref_err) && !eff.rst_irq_sel)
                reset_req_r <= 1'b1; // [RL10]
        end
    end

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_st_r <= 2'h0;
        else if (wr_en && paddr == `IWW_OFF_IRQ_CLR)
            irq_st_r <= (irq_st_r & ~pwdata[1:0]) | {ref_err, underflow};
        else
            irq_st_r <= irq_st_r | {ref_err, underflow};
    end

    assign irq             = |(irq_st_r & irq_en_r);
    assign evt_underflow   = evt_uf_r;
    assign evt_refresh_err = evt_err_r;
    assign nmi_req         = nmi_r;
    assign wdt_reset_req   = reset_req_r;
    assign sleep_stop_ctrl = slc_out_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_refresh_in;
        ref_ok && (st_r == iww_pkg::ST_COUNT);
    endsequence
    sequence s_event;
        underflow || ref_err;
    endsequence
    property p_reload_top;
        s_refresh_in |=> (cnt_r == $past(top)) && (st_r == iww_pkg::ST_COUNT);
    endproperty
    a_reload_top: assert property (p_reload_top) else $error("refresh did not reload"); // [RL4]
    property p_top128;
        reload && (eff.timeout_period_select == 2'h0) |=> cnt_r == 14'h007F;
    endproperty
    a_top128: assert property (p_top128) else $error("period 00 start value wrong"); // [RL15]
    property p_decrement;
        !reload && tick && (cnt_r != 14'h0000) |=> cnt_r == $past(cnt_r) - 14'h0001;
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter missed a tick"); // [RL2]
    property p_stop;
        s_event |=> st_r == iww_pkg::ST_STOP;
    endproperty
    a_stop: assert property (p_stop) else $error("counting did not stop"); // [RL6]
    property p_stop_evt;
        underflow |=> (st_r == iww_pkg::ST_STOP) && evt_underflow && !evt_refresh_err;
    endproperty
    a_stop_evt: assert property (p_stop_evt) else $error("underflow did not stop"); // [RL6]
    property p_err_evt;
        ref_err |=> (st_r == iww_pkg::ST_STOP) && evt_refresh_err && irq_st_r[`IWW_IRQ_ERR];
    endproperty
    a_err_evt: assert property (p_err_evt) else $error("refresh error missed"); // [RL10]
    // a reset request raised earlier stands until reset, so only its change is forbidden here
    property p_nmi;
        (underflow || ref_err) && eff.rst_irq_sel |=> nmi_req && (wdt_reset_req == $past(wdt_reset_req));
    endproperty
    a_nmi: assert property (p_nmi) else $error("interrupt request missing"); // [RL14]
    property p_auto_resume;
        (st_r == iww_pkg::ST_STOP) && opt_r.auto_start && eff.rst_irq_sel
            |=> (st_r == iww_pkg::ST_COUNT) && (cnt_r == $past(top));
    endproperty
    a_auto_resume: assert property (p_auto_resume) else $error("auto resume failed"); // [RL7]
    property p_reg_halt;
        (st_r == iww_pkg::ST_STOP) && !opt_r.auto_start && !refresh_hit |=> st_r == iww_pkg::ST_STOP;
    endproperty
    a_reg_halt: assert property (p_reg_halt) else $error("restart without refresh"); // [RL8]
    property p_status_read;
        rd_setup && (paddr == `IWW_OFF_STATUS) |=> prdata[13:0] == $past(cnt_r);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status shows wrong count"); // [RL11]
    property p_bad_seq;
        wr_en && (paddr == `IWW_OFF_REFRESH) && !pend00_r |=> $stable(cnt_r) || $past(tick);
    endproperty
    a_bad_seq: assert property (p_bad_seq) else $error("refresh without 00h"); // [RL16]

endmodule
`default_nettype wire

/* File: design/iww_params.svh */
// constants of the independent window watchdog: offsets, fields, reset values, counts
// included by the watchdog package users; holds definitions only
`ifndef IWW_PARAMS_SVH
`define IWW_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define IWW_OFF_REFRESH   8'h00
`define IWW_OFF_CTRL      8'h04
`define IWW_OFF_STATUS    8'h08
`define IWW_OFF_RSTCTL    8'h0C
`define IWW_OFF_STOPCTL   8'h10
`define IWW_OFF_IRQ_ST    8'h14
`define IWW_OFF_IRQ_CLR   8'h18
`define IWW_OFF_IRQ_EN    8'h1C

// ****************************************
// refresh sequence bytes
// ****************************************
`define IWW_REFRESH_FIRST 8'h00
`define IWW_REFRESH_LAST  8'hFF

// ****************************************
// field positions
// ****************************************
`define IWW_CTRL_TPS_LSB  0
`define IWW_CTRL_CKS_LSB  4
`define IWW_CTRL_RPES_LSB 8
`define IWW_CTRL_RPSS_LSB 12
`define IWW_RSTCTL_SEL    7
`define IWW_STOPCTL_SLC   0
`define IWW_STATUS_UF     14
`define IWW_STATUS_ERR    15
`define IWW_IRQ_UF        0
`define IWW_IRQ_ERR       1

// ****************************************
// reset values
// ****************************************
`define IWW_CTRL_RST      16'h3333
`define IWW_RSTCTL_RST    1'b0
`define IWW_STOPCTL_RST   1'b0

// ****************************************
// timeout start values per period select
// ****************************************
`define IWW_TOP_SEL0      14'h007F
`define IWW_TOP_SEL1      14'h01FF
`define IWW_TOP_SEL2      14'h03FF
`define IWW_TOP_SEL3      14'h07FF

// ****************************************
// prescaler terminal counts (ratio minus one)
// ****************************************
`define IWW_DIV_1         8'h00
`define IWW_DIV_16        8'h0F
`define IWW_DIV_32        8'h1F
`define IWW_DIV_64        8'h3F
`define IWW_DIV_128       8'h7F
`define IWW_DIV_256       8'hFF

`endif

/* File: design/iww_pkg.sv */
// types of the independent window watchdog
// constants live in iww_params.svh
package iww_pkg;

    // watchdog configuration, from the option word or from the control registers
    typedef struct packed {
        logic       auto_start;
        logic       rst_irq_sel;
        logic       slcstp;
        logic [1:0] rpss;
        logic [1:0] rpes;
        logic [2:0] cks;
        logic [1:0] timeout_period_select;
    } iww_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_COUNT = 3'b010,
        ST_STOP  = 3'b100
    } iww_state_t;

endpackage

/* File: design/iww_prescaler.sv */
// count-tick prescaler of the watchdog: divides the dedicated clock enable
// assumes tick_in is a one-cycle enable synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "iww_params.svh"

module iww_prescaler #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // control
    input  wire logic             run,
    input  wire logic             clr,
    input  wire logic [2:0]       sel,
    input  wire logic             tick_in,
    // divided tick
    output logic                  tick_out
);

    // elaboration refuses a counter too short for the slowest ratio
    if (CNT_W < 8)
    begin : g_width_check
        $error("iww_prescaler: CNT_W must hold a divide by 256");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] last;

    // selections above 5 fall back to the slowest ratio
    always_comb
    begin
        case (sel)
            3'h0:    last = CNT_W'(`IWW_DIV_1);
            3'h1:    last = CNT_W'(`IWW_DIV_16);
            3'h2:    last = CNT_W'(`IWW_DIV_32);
            3'h3:    last = CNT_W'(`IWW_DIV_64);
            3'h4:    last = CNT_W'(`IWW_DIV_128);
            default: last = CNT_W'(`IWW_DIV_256);
        endcase
    end

    assign tick_out = run && tick_in && (cnt_r == last); // [RL1]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= '0;
        else if (clr || tick_out)
            cnt_r <= '0;
        else if (run && tick_in)
            cnt_r <= cnt_r + CNT_W'(1);
    end

endmodule
`default_nettype wire

/* File: testbench/iww_sys_ctrl.sv */
// partner model: system reset and interrupt control facing the watchdog
// assumes the watchdog requests are synchronous to pclk
`timescale 1ns/1ps
`default_nettype none

module iww_sys_ctrl (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // watchdog requests
    input  wire logic       wdt_reset_req,
    input  wire logic       nmi_req,
    // observed totals
    output logic            sys_rst_seen,
    output logic [7:0]      nmi_count
);
    // ****************************************
    // request capture
    // ****************************************
    // interrupt pulses are counted and the reset request is only latched, so an interrupt request stuck high shows up as too many
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_rst_seen <= 1'b0;
            nmi_count    <= 8'h00;
        end
        else
        begin
            sys_rst_seen <= sys_rst_seen | wdt_reset_req;
            nmi_count    <= nmi_count + {7'h00, nmi_req};
        end
    end
endmodule

`default_nettype wire

/* File: testbench/independent_window_watchdog_test.sv */
// self-checking bench of the window watchdog against a counting model
// assumes iww_params.svh on the include path; ticks spaced six cycles apart
`timescale 1ns/1ps
`default_nettype none
`include "iww_params.svh"

module independent_window_watchdog_test;
    // ****************************************
    // signals and model state
    // ****************************************
    logic               pclk, presetn, psel, penable, pwrite, wdt_tick, sleep_mode;
    logic [7:0]         paddr, nmi_count;
    logic [31:0]        pwdata, prdata, rd;
    logic               pready, pslverr, er, wdt_reset_req, nmi_req, irq;
    logic               evt_underflow, evt_refresh_err, sleep_stop_ctrl, sys_rst_seen;
    iww_pkg::iww_cfg_t  opt;
    int                 fails, compares, seed, n_uf, n_err;
    int                 m_cnt, m_top, m_div, m_pre, m_rpss, m_uf, m_err, m_nmi;
    int                 m_su, m_se, m_run, m_auto, m_irqm, m_slp, m_rpes;

    iww_top u_iww_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_tick(wdt_tick), .sleep_mode(sleep_mode),
        .option_config_word(opt), .wdt_reset_req(wdt_reset_req), .nmi_req(nmi_req),
        .evt_underflow(evt_underflow), .evt_refresh_err(evt_refresh_err),
        .sleep_stop_ctrl(sleep_stop_ctrl), .irq(irq));
    iww_sys_ctrl u_iww_sys_ctrl (.pclk(pclk), .presetn(presetn), .wdt_reset_req(wdt_reset_req),
        .nmi_req(nmi_req), .sys_rst_seen(sys_rst_seen), .nmi_count(nmi_count));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (evt_underflow === 1'b1) n_uf++;
        if (evt_refresh_err === 1'b1) n_err++;
    end

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int g;
        g = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            g++;
        end
        while (pready !== 1'b1 && g < 20);
        if (pready !== 1'b1)
        begin
            fails++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdst();
        apb(1'b0, `IWW_OFF_STATUS, 32'h0);
        chk(rd, 32'((m_se << 15) | (m_su << 14) | m_cnt));
    endtask

    // each tick models the prescaler and the down-counter
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk) wdt_tick <= 1'b1;
            @(posedge pclk) wdt_tick <= 1'b0;
            repeat (4) @(posedge pclk);
            if (m_run && !m_slp)
                m_pre++;
            if (m_run && !m_slp && m_pre == m_div)
            begin
                m_pre = 0;
                if (m_cnt > 0)
                    m_cnt--;
                else
                begin
                    m_uf++;
                    m_su = 1;
                    m_nmi += m_irqm;
                    m_run = m_auto;
                    if (m_auto) m_cnt = m_top;
                end
            end
        end
    endtask

    task automatic refresh();
        apb(1'b1, `IWW_OFF_REFRESH, 32'h00);
        apb(1'b1, `IWW_OFF_REFRESH, 32'hFF);
        if (m_run && (m_cnt > (m_top + 1) / 4 * (4 - m_rpss) - 1 || m_cnt < (m_top + 1) / 4 * m_rpes))
        begin
            m_err++;
            m_se = 1;
            m_nmi += m_irqm;
            m_run = 0;
        end
        else
        begin
            m_cnt = m_top;
            m_pre = 0;
            m_run = 1;
        end
        repeat (2) @(posedge pclk);
    endtask

    task automatic do_reset(input iww_pkg::iww_cfg_t o);
        @(posedge pclk);
        presetn <= 1'b0;
        opt     <= o;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        {n_uf, n_err, m_uf, m_err, m_nmi, m_su, m_se, m_pre, m_slp} = '0;
        {m_auto, m_irqm, m_run} = {32'(o.auto_start), 32'(o.rst_irq_sel), 32'(o.auto_start)};
        {m_top, m_div, m_rpss, m_rpes} = {32'h7F, 32'h1, 32'h0, 32'h0};
        m_cnt = o.auto_start ? 'h7F : 0;
        repeat (3) @(posedge pclk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {fails, compares, psel, penable, pwrite, paddr, pwdata, wdt_tick, sleep_mode} = '0;
        {presetn, opt} = '0;
        seed = 80031;
        do_reset('0);
        apb(1'b0, `IWW_OFF_CTRL, 32'h0);
        chk(rd, 32'(`IWW_CTRL_RST));
        rdst();
        tick(3);
        rdst();
        apb(1'b1, 8'h20, $random(seed));
        chk(32'(er), 32'h1);
        apb(1'b1, `IWW_OFF_CTRL, 32'h0);
        apb(1'b1, `IWW_OFF_IRQ_EN, 32'h1);
        apb(1'b1, `IWW_OFF_REFRESH, 32'h00);
        apb(1'b1, `IWW_OFF_REFRESH, 32'(($random(seed) & 'h7E) | 1));
        apb(1'b1, `IWW_OFF_REFRESH, 32'hFF);
        rdst();
        refresh();
        rdst();
        tick(1 + ($random(seed) & 15));
        rdst();
        tick(m_cnt + 1);
        rdst();
        chk(n_uf, m_uf);
        chk(32'({sys_rst_seen, wdt_reset_req, irq}), 32'h7);
        tick(3);
        rdst();
        apb(1'b1, `IWW_OFF_IRQ_CLR, 32'h3);
        m_su = 0;
        apb(1'b1, `IWW_OFF_RSTCTL, 32'h80);
        apb(1'b1, `IWW_OFF_CTRL, 32'h3010);
        chk(32'(irq), 32'h0);
        {m_irqm, m_div, m_rpss} = {32'h1, 32'h10, 32'h3};
        refresh();
        tick(16);
        rdst();
        refresh();
        chk(32'({n_err, irq}), 32'({m_err, 1'b0}));
        apb(1'b1, `IWW_OFF_IRQ_EN, 32'h3);
        @(posedge pclk);
        chk(32'({nmi_count, irq}), 32'({m_nmi[7:0], 1'b1}));
        apb(1'b1, `IWW_OFF_CTRL, 32'h3000);
        m_div = 1;
        refresh();
        tick(m_top - 20);
        refresh();
        rdst();
        chk(n_err, m_err);
        apb(1'b1, `IWW_OFF_STOPCTL, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(sleep_stop_ctrl), 32'h1);
        sleep_mode <= 1'b1;
        m_slp = 1;
        tick(4);
        rdst();
        sleep_mode <= 1'b0;
        m_slp = 0;
        tick(1);
        rdst();
        // window end a quarter up from zero: a late refresh is an error
        apb(1'b1, `IWW_OFF_CTRL, 32'h0100);
        {m_rpss, m_rpes} = {32'h0, 32'h1};
        tick(m_cnt - 10);
        refresh();
        chk(n_err, m_err);
        do_reset('{auto_start: 1'b1, rst_irq_sel: 1'b1, default: '0});
        opt <= '0;
        chk(32'(wdt_reset_req), 32'h0);
        rdst();
        tick(m_cnt + 1);
        chk(32'(nmi_count), m_nmi);
        tick(2);
        rdst();
        print_verdict();
    end
endmodule

`default_nettype wire
